// File: olc_office_comparator.sv
// Office-level ambient light comparator with its two setting registers.
// Assumes the sensor sample, the enable and the dark comparator result all
// come from logic on clk, so none of them is synchronised here.
// The comparator keeps one bit of state, the office decision, and the
// registered backlight mode follows from it with the dark override on top.
// Settings above the recommended range are stored as written; the status
// output only reports them, because the host owns the legal range.
// A sample is acted on only in the cycle its valid strobe is high; between
// samples the last decision stands unless the enable drops.
// The dark input is a level that overrides the mode for as long as it is
// high, but it never touches the office decision itself.
//
// Contract
// - Current below threshold selects office mode.
// - Current above threshold plus hysteresis selects daylight.
// - Threshold is 8-bit code, 4.3 uA steps.
// - Hysteresis is 8-bit code, same scale.
// - Comparison acts only while its enable is set.
// - Dark comparator result overrides office comparator.
module olc_office_comparator
(
    input wire logic clk,
    input wire logic rst,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData_q,
    input wire logic sampleValid,
    input wire logic [olc_pkg::CODE_WIDTH:0] sensorCode,
    input wire logic officeCompareEnable,
    input wire logic darkLevelComparator,
    output logic officeCompareOut_q,
    output olc_pkg::olc_mode_t backlightMode_q,
    output logic settingsIllegal_q
);

    ////////////////////////////////////////////////////////////////////////
    // Setting registers.
    // Both codes share one scale: one step is STEP_CURRENT_NA of sensor current.
    logic [olc_pkg::CODE_WIDTH-1:0] officeThresholdCode_q;
    logic [olc_pkg::CODE_WIDTH-1:0] officeHysteresisCode_q;
    logic [olc_pkg::SUM_WIDTH-1:0] releaseLevel;
    logic officeCompare_d;
    olc_pkg::olc_mode_t backlightMode_d;
    logic thresholdSelected;
    logic hysteresisSelected;
    logic belowTrip;
    logic aboveRelease;
    logic settingsIllegal_d;

    // Widens an 8-bit code to the width of the sum of two codes.
    function automatic logic [olc_pkg::SUM_WIDTH-1:0] widenCode
    (
        input logic [olc_pkg::CODE_WIDTH-1:0] code
    );
        widenCode = {1'b0, code};
    endfunction

    // True when the register address equals the given register's address, with or without a strobe.
    function automatic logic addrMatch
    (
        input logic [7:0] addr,
        input logic [7:0] target
    );
        addrMatch = (addr == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address decode shared by the write and read paths.
    assign thresholdSelected = addrMatch(regAddr, olc_pkg::OFFICE_THRESHOLD_ADDR);
    assign hysteresisSelected = addrMatch(regAddr, olc_pkg::OFFICE_HYSTERESIS_ADDR);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            officeThresholdCode_q <= olc_pkg::OFFICE_THRESHOLD_RESET;
        end
        else if (regWrEn && thresholdSelected)
        begin
            // Every 8-bit code is stored, including those software should avoid.
            officeThresholdCode_q <= regWrData;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            officeHysteresisCode_q <= olc_pkg::OFFICE_HYSTERESIS_RESET;
        end
        else if (regWrEn && hysteresisSelected)
        begin
            officeHysteresisCode_q <= regWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: data is registered and stands until the next read.

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            regRdData_q <= olc_pkg::UNMAPPED_READ_VALUE;
        end
        else if (regRdEn)
        begin
            if (thresholdSelected)
            begin
                regRdData_q <= officeThresholdCode_q;
            end
            else if (hysteresisSelected)
            begin
                regRdData_q <= officeHysteresisCode_q;
            end
            else
            begin
                // Unmapped addresses read as a fixed value.
                regRdData_q <= olc_pkg::UNMAPPED_READ_VALUE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flag for settings outside the recommended range.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            settingsIllegal_q <= 1'b0;
        end
        else
        begin
            settingsIllegal_q <= settingsIllegal_d;
        end
    end

    // Flags, but does not block, settings the host must avoid. A single code
    // above the limit shows here too, since the sum is at least as large.
    assign settingsIllegal_d = (releaseLevel > widenCode(olc_pkg::MAX_LEGAL_CODE));

    ////////////////////////////////////////////////////////////////////////
    // Comparator with hysteresis.
    // A sample below the threshold asks for office mode and a sample above
    // threshold plus hysteresis asks for daylight. Samples in the band between,
    // either edge included, leave the decision alone, so a light level that
    // wanders near one edge cannot make the backlight flicker.
    // The sum is one bit wider so that illegal settings cannot wrap around.
    assign releaseLevel = widenCode(officeThresholdCode_q) + widenCode(officeHysteresisCode_q);
    assign belowTrip = (sensorCode < widenCode(officeThresholdCode_q));
    assign aboveRelease = (sensorCode > releaseLevel);

    always_comb
    begin
        officeCompare_d = officeCompareOut_q;
        // A disabled comparator forgets its decision, so re-enabling it
        // starts from daylight until the first sample arrives.
        if (!officeCompareEnable)
        begin
            officeCompare_d = 1'b0;
        end
        else if (sampleValid)
        begin
            if (belowTrip)
            begin
                officeCompare_d = 1'b1;
            end
            else if (aboveRelease)
            begin
                officeCompare_d = 1'b0;
            end
            else
            begin
                officeCompare_d = officeCompareOut_q;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            officeCompareOut_q <= 1'b0;
        end
        else
        begin
            officeCompareOut_q <= officeCompare_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Backlight mode selection.
    // The mode follows the next office decision so that it lands on the same
    // edge as the comparator output; the dark request wins over both office
    // and daylight while it is present.
    always_comb
    begin
        if (darkLevelComparator)
        begin
            backlightMode_d = olc_pkg::OLC_DARK;
        end
        else if (officeCompare_d)
        begin
            backlightMode_d = olc_pkg::OLC_OFFICE;
        end
        else
        begin
            backlightMode_d = olc_pkg::OLC_DAYLIGHT;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            backlightMode_q <= olc_pkg::OLC_DAYLIGHT;
        end
        else
        begin
            backlightMode_q <= backlightMode_d;
        end
    end

endmodule

// File: olc_pkg.sv
// Package for the office-level ambient light comparator.
// Assumes a host register port on the same clock as the comparator.
package olc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map.
    localparam logic [7:0] OFFICE_THRESHOLD_ADDR = 8'h1d;
    localparam logic [7:0] OFFICE_HYSTERESIS_ADDR = 8'h1e;
    localparam logic [7:0] OFFICE_THRESHOLD_RESET = 8'h00;
    localparam logic [7:0] OFFICE_HYSTERESIS_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Code scale: one code step is this many nanoamperes of sensor current.
    localparam int STEP_CURRENT_NA = 4300;
    localparam int CODE_WIDTH = 8;
    localparam int SUM_WIDTH = CODE_WIDTH + 1;
    // Largest sum of threshold and hysteresis that software may program.
    localparam logic [CODE_WIDTH-1:0] MAX_LEGAL_CODE = 8'hfa;

    ////////////////////////////////////////////////////////////////////////
    // Backlight modes.
    typedef enum logic [1:0]
    {
        OLC_DAYLIGHT = 2'b00,
        OLC_OFFICE = 2'b01,
        OLC_DARK = 2'b10
    } olc_mode_t;

endpackage

// File: olc_sensor_model.sv
// Phototransistor stand-in that hands conversion samples to the comparator.
// Assumes the bench raises fire for one cycle per sample.
module olc_sensor_model
(
    input wire logic clk,
    input wire logic fire,
    input wire logic [8:0] level,
    output logic sampleValid,
    output logic [8:0] sensorCode
);
    logic [8:0] last_q = 9'h000;
    always_ff @(posedge clk)
        if (fire)
            last_q <= level;
    // Between samples the code is scrambled so a stale value never looks valid.
    assign sampleValid = fire;
    assign sensorCode = fire ? level : ~last_q;
endmodule

// File: olc_monitor.sv
// Port checker for the office light comparator.
// Assumes it is bound onto olc_office_comparator.
module olc_monitor
(
    input wire logic clk,
    input wire logic rst,
    input wire logic regWrEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic sampleValid,
    input wire logic [8:0] sensorCode,
    input wire logic officeCompareEnable,
    input wire logic darkLevelComparator,
    input wire logic officeCompareOut_q,
    input wire olc_pkg::olc_mode_t backlightMode_q
);
    logic [7:0] thr_q;
    logic [7:0] hys_q;
    wire [8:0] upper = {1'b0, thr_q} + {1'b0, hys_q};
    wire take = sampleValid && officeCompareEnable;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            thr_q <= 8'h00;
        else if (regWrEn && regAddr == olc_pkg::OFFICE_THRESHOLD_ADDR)
            thr_q <= regWrData;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            hys_q <= 8'h00;
        else if (regWrEn && regAddr == olc_pkg::OFFICE_HYSTERESIS_ADDR)
            hys_q <= regWrData;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_OFFICE: assert property (take && !darkLevelComparator && sensorCode < thr_q
        |=> officeCompareOut_q && backlightMode_q == olc_pkg::OLC_OFFICE) else $error("no office");
    AST_DAY: assert property (take && !darkLevelComparator && sensorCode > upper
        |=> !officeCompareOut_q && backlightMode_q == olc_pkg::OLC_DAYLIGHT) else $error("no day");
    AST_HOLD: assert property (take && sensorCode >= thr_q && sensorCode <= upper
        |=> $stable(officeCompareOut_q)) else $error("hold lost");
    AST_AT_THR: assert property (take && sensorCode == {1'b0, thr_q}
        |=> officeCompareOut_q == $past(officeCompareOut_q)) else $error("threshold edge");
    AST_OVER_HYS: assert property (take && !darkLevelComparator && sensorCode == upper + 9'h001
        |=> backlightMode_q == olc_pkg::OLC_DAYLIGHT) else $error("hysteresis edge");
    AST_OFF: assert property (!officeCompareEnable |=> !officeCompareOut_q) else $error("enable");
    AST_DARK: assert property (darkLevelComparator
        |=> backlightMode_q == olc_pkg::OLC_DARK) else $error("dark lost");
endmodule
bind olc_office_comparator olc_monitor i_olc_monitor
(
    .clk(clk), .rst(rst), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
    .sampleValid(sampleValid), .sensorCode(sensorCode), .officeCompareEnable(officeCompareEnable),
    .darkLevelComparator(darkLevelComparator), .officeCompareOut_q(officeCompareOut_q),
    .backlightMode_q(backlightMode_q)
);

// File: tb_office_level_light_comparator.sv
// Bench comparing the office light comparator with an integer model.
// Assumes the sensor model and the checker are compiled before it.
module tb_office_level_light_comparator;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic regWrEn = 1'b0, regRdEn = 1'b0, fire = 1'b0, en = 1'b0, dark = 1'b0, outQ, sv, ill;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, rdQ;
    logic [8:0] level = 9'h000, code;
    olc_pkg::olc_mode_t bm;
    int failures = 0, nCompared = 0, thr = 0, hys = 0, out = 0, seed = 32'he03d3fe8;
    int pts[$] = '{30, 40, 50, 51, 40, 39};
    always #25 clk = ~clk;
    olc_office_comparator i_olc_office_comparator
    (
        .clk(clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData_q(rdQ), .sampleValid(sv), .sensorCode(code),
        .officeCompareEnable(en), .darkLevelComparator(dark), .officeCompareOut_q(outQ),
        .backlightMode_q(bm), .settingsIllegal_q(ill)
    );
    olc_sensor_model i_olc_sensor_model
    (
        .clk(clk), .fire(fire), .level(level), .sampleValid(sv), .sensorCode(code)
    );
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nCompared++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {regAddr, regWrData, regWrEn} <= {a, d, 1'b1};
        @(negedge clk);
        regWrEn <= 1'b0;
        thr = (a == olc_pkg::OFFICE_THRESHOLD_ADDR) ? d : thr;
        hys = (a == olc_pkg::OFFICE_HYSTERESIS_ADDR) ? d : hys;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        {regAddr, regRdEn} <= {a, 1'b1};
        @(negedge clk);
        regRdEn <= 1'b0;
        @(negedge clk);
        chk(rdQ, exp);
    endtask
    task automatic smp(input int c, input logic e, input logic k);
        {level, fire, en, dark} <= {c[8:0], 1'b1, e, k};
        @(negedge clk);
        fire <= 1'b0;
        @(negedge clk);
        out = !e ? 0 : (c < thr) ? 1 : (c > thr + hys) ? 0 : out;
        chk({5'h0, outQ, bm}, {5'h0, out[0], k ? 2'b10 : {1'b0, out[0]}});
        chk({7'h00, ill}, (thr + hys > 250) ? 8'h01 : 8'h00);
    endtask
    task automatic give_verdict();
        $display("compared %0d failures %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        rd(olc_pkg::OFFICE_THRESHOLD_ADDR, olc_pkg::OFFICE_THRESHOLD_RESET);
        wr(olc_pkg::OFFICE_THRESHOLD_ADDR, 8'h28);
        wr(olc_pkg::OFFICE_HYSTERESIS_ADDR, 8'h0a);
        wr(8'h55, 8'hff);
        rd(olc_pkg::OFFICE_THRESHOLD_ADDR, 8'h28);
        rd(8'h55, olc_pkg::UNMAPPED_READ_VALUE);
        foreach (pts[i])
            smp(pts[i], 1'b1, 1'b0);
        smp(100, 1'b1, 1'b1);
        smp(30, 1'b0, 1'b0);
        wr(olc_pkg::OFFICE_THRESHOLD_ADDR, 8'hf0);
        wr(olc_pkg::OFFICE_HYSTERESIS_ADDR, 8'h14);
        smp(255, 1'b1, 1'b0);
        wr(olc_pkg::OFFICE_THRESHOLD_ADDR, 8'h28);
        wr(olc_pkg::OFFICE_HYSTERESIS_ADDR, 8'h0a);
        repeat (300)
        begin
            if ({$random(seed)} % 8 == 0)
            begin
                wr(olc_pkg::OFFICE_THRESHOLD_ADDR, 8'({$random(seed)} % 251));
                wr(olc_pkg::OFFICE_HYSTERESIS_ADDR, 8'({$random(seed)} % (251 - thr)));
                rd(olc_pkg::OFFICE_HYSTERESIS_ADDR, hys[7:0]);
            end
            smp({$random(seed)} % 320, {$random(seed)} % 8 != 0, {$random(seed)} % 8 == 0);
        end
        give_verdict();
    end
    initial
    begin
        #1000000;
        failures++;
        give_verdict();
    end
endmodule
